//--- logic/hwd_pkg.sv
// Purpose: Constants and types shared by the hardware watchdog block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses on the peripheral bus

package hwd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam int          HWD_ADDR_W               = 12;
    localparam logic [11:0] HWD_OFS_LOAD             = 12'h000;
    localparam logic [11:0] HWD_OFS_COUNT_VALUE      = 12'h004;
    localparam logic [11:0] HWD_OFS_CONTROL          = 12'h008;
    localparam logic [11:0] HWD_OFS_CLEAR            = 12'h00C;
    localparam logic [11:0] HWD_OFS_IRQ_STATUS       = 12'h010;
    localparam logic [11:0] HWD_OFS_KEY              = 12'h014;

    ////////////////////////////////////////////////////////////////////////////////
    // Keys, reset values, field positions
    localparam logic [31:0] HWD_KEY_FIRST            = 32'h1ACC_E551;
    localparam logic [31:0] HWD_KEY_SECOND           = 32'hE533_1AAE;
    localparam logic [31:0] HWD_LOAD_RESET           = 32'h0000_FFFF;
    localparam int          HWD_CLEAR_W              = 8;
    localparam int          HWD_CTRL_IRQ_EN_BIT      = 0;
    localparam int          HWD_CTRL_RST_EN_BIT      = 1;
    localparam logic        HWD_CTRL_IRQ_EN_RESET    = 1'b1;
    localparam logic        HWD_CTRL_RST_EN_RESET    = 1'b1;
    localparam int          HWD_KEY_LOCKED_BIT       = 0;
    localparam int          HWD_KEY_CTRL_OPEN_BIT    = 1;
    localparam int          HWD_SYNC_STAGES          = 3;
    localparam int          HWD_RST_STAGES           = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        HWD_LOCKED,
        HWD_OPEN_MOST,
        HWD_OPEN_ALL
    } hwd_lock_t;

    typedef struct packed {
        logic rst_en;
        logic irq_and_count_enable;
    } hwd_ctrl_t;

    localparam hwd_ctrl_t   HWD_CTRL_RESET = '{rst_en:               HWD_CTRL_RST_EN_RESET,
                                               irq_and_count_enable: HWD_CTRL_IRQ_EN_RESET};

endpackage

//--- logic/hwd_hardware_watchdog.sv
// Purpose: Hardware watchdog: 32-bit down counter, two-key lock, byte+inverse clear
// Assumes: Low-speed oscillator arrives as a pin far slower than mclk
// Notes:   Counts on sampled oscillator edges; stop mode simply stalls those edges
//
// The register addresses and register access over APB were chosen for this implementation.

`timescale 1ns/10ps

module hwd_hardware_watchdog
    import hwd_pkg::*;
#(
    parameter int ADDR_W = HWD_ADDR_W
)
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output      logic [31:0]       prdata,
    output      logic              pready,
    output      logic              pslverr,
    input  wire logic              low_speed_rc_clock,
    input  wire logic              debug_break,
    output      logic              wdt_irq,
    output      logic              wdt_reset_req
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [HWD_RST_STAGES-1:0] rst_sync;
    logic                      rst_int_b;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync <= '0;
        else
            rst_sync <= {rst_sync[HWD_RST_STAGES-2:0], 1'b1};
    end

    assign rst_int_b = rst_sync[HWD_RST_STAGES-1];

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers with agreement filter
    localparam int PINS = 2;

    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_level;
    logic [PINS-1:0] pin_rise;
    logic            brk_level;
    logic            osc_tick;

    // Bit 0 oscillator, bit 1 debug break
    assign pin_raw = {debug_break, low_speed_rc_clock};

    generate
        for (genvar i = 0; i < PINS; i++)
        begin : g_pin
            logic [HWD_SYNC_STAGES-1:0] stages;
            logic                       level;
            logic                       agree;

            // Change counts once second and third stage agree
            assign agree = stages[1] == stages[2];

            always_ff @(posedge mclk or negedge rst_int_b)
            begin
                if (!rst_int_b)
                begin
                    stages <= '0;
                    level  <= 1'b0;
                end
                else
                begin
                    stages <= {stages[1:0], pin_raw[i]};
                    if (agree)
                        level <= stages[2];
                end
            end

            assign pin_level[i] = level;
            assign pin_rise[i]  = agree & stages[2] & ~level;
        end
    endgenerate

    assign brk_level = pin_level[1];
    assign osc_tick  = pin_rise[0];

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        addr_is = a == ADDR_W'(ofs);
    endfunction

    hwd_lock_t   lock;
    hwd_lock_t   next_lock;
    hwd_ctrl_t   ctrl;
    logic [31:0] load;
    logic [31:0] count;
    logic        irq_flag;
    logic [HWD_CLEAR_W-1:0] clr_byte;
    logic        clr_pending;

    logic        sel_load;
    logic        sel_count;
    logic        sel_ctrl;
    logic        sel_clear;
    logic        sel_status;
    logic        sel_key;
    logic        mapped;
    logic        setup;
    logic        wr_access;
    logic        unlocked;
    logic        acc_load;
    logic        acc_ctrl;
    logic        acc_clear;
    logic        acc_key;
    logic        key_first;
    logic        key_second;
    logic        wr_load;
    logic        wr_ctrl;
    logic        wr_clear;
    logic        clear_end;
    logic        clear_ok;

    // Address match, one register each
    assign sel_load   = addr_is(paddr, HWD_OFS_LOAD);
    assign sel_count  = addr_is(paddr, HWD_OFS_COUNT_VALUE);
    assign sel_ctrl   = addr_is(paddr, HWD_OFS_CONTROL);
    assign sel_clear  = addr_is(paddr, HWD_OFS_CLEAR);
    assign sel_status = addr_is(paddr, HWD_OFS_IRQ_STATUS);
    assign sel_key    = addr_is(paddr, HWD_OFS_KEY);
    assign mapped     = sel_load | sel_count | sel_ctrl | sel_clear | sel_status | sel_key;

    // Bus phases
    assign setup      = psel & ~penable;
    assign wr_access  = psel & penable & pwrite & mapped;
    assign unlocked   = lock != HWD_LOCKED;

    // Write strobes, before the lock is applied
    assign acc_load   = wr_access & sel_load;
    assign acc_ctrl   = wr_access & sel_ctrl;
    assign acc_clear  = wr_access & sel_clear;
    assign acc_key    = wr_access & sel_key;

    // Key compare
    assign key_first  = pwdata == HWD_KEY_FIRST;
    assign key_second = pwdata == HWD_KEY_SECOND;

    // Write strobes that pass the lock
    assign wr_load    = acc_load & unlocked;
    assign wr_ctrl    = acc_ctrl & (lock == HWD_OPEN_ALL);
    assign wr_clear   = acc_clear & unlocked;
    assign clear_end  = wr_clear & clr_pending;
    assign clear_ok   = clear_end &
                        (pwdata[HWD_CLEAR_W-1:0] == ~clr_byte);

    ////////////////////////////////////////////////////////////////////////////////
    // Lock sequencer
    always_comb
    begin
        next_lock = lock;
        case (lock)
            HWD_LOCKED:
            begin
                if (acc_key && key_first)
                    next_lock = HWD_OPEN_MOST;
            end
            HWD_OPEN_MOST:
            begin
                if (acc_key)
                    next_lock = key_second ? HWD_OPEN_ALL :
                                key_first  ? HWD_OPEN_MOST :
                                             HWD_LOCKED;
                else if (acc_load || acc_ctrl || clear_end)
                    next_lock = HWD_LOCKED;
            end
            HWD_OPEN_ALL:
            begin
                if (acc_key && !key_second)
                    next_lock = key_first ? HWD_OPEN_MOST : HWD_LOCKED;
                else if (acc_load || clear_end)
                    next_lock = HWD_LOCKED;
            end
            default:
                next_lock = HWD_LOCKED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter and underflow
    logic        run;
    logic        new_en;
    logic        en_rise;
    logic        en_fall;
    logic        tick;
    logic        underflow;
    logic        fire;

    // Debug break stalls counting so count reads are exact
    assign run       = ctrl.irq_and_count_enable & ~brk_level;
    assign new_en    = pwdata[HWD_CTRL_IRQ_EN_BIT];
    assign en_rise   = wr_ctrl & new_en & ~ctrl.irq_and_count_enable;
    assign en_fall   = wr_ctrl & ~new_en;
    assign tick      = run & osc_tick;

    // A reload in the same cycle hides the underflow
    assign underflow = tick & (count == 32'h0000_0000) & ~clear_ok & ~wr_load & ~en_rise;
    assign fire      = underflow & irq_flag & ctrl.rst_en;
    logic [31:0] next_count;
    logic        next_flag;

    always_comb
    begin
        if (clear_ok || en_rise)
            next_count = load;
        else if (wr_load)
            next_count = pwdata;
        else if (underflow)
            next_count = load;
        else if (tick)
            next_count = count - 32'h0000_0001;
        else
            next_count = count;
    end

    // Set wins over clear
    assign next_flag = underflow | (irq_flag & ~clear_ok & ~en_fall);

    always_ff @(posedge mclk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            lock          <= HWD_LOCKED;
            ctrl          <= HWD_CTRL_RESET;
            load          <= HWD_LOAD_RESET;
            count         <= HWD_LOAD_RESET;
            irq_flag      <= 1'b0;
            clr_pending   <= 1'b0;
            clr_byte      <= '0;
            wdt_reset_req <= 1'b0;
        end
        else if (fire)
        begin
            lock          <= HWD_LOCKED;
            ctrl          <= HWD_CTRL_RESET;
            load          <= HWD_LOAD_RESET;
            count         <= HWD_LOAD_RESET;
            irq_flag      <= 1'b0;
            clr_pending   <= 1'b0;
            clr_byte      <= '0;
            wdt_reset_req <= 1'b1;
        end
        else
        begin
            lock          <= next_lock;
            count         <= next_count;
            irq_flag      <= next_flag;
            wdt_reset_req <= 1'b0;
            if (wr_load)
                load <= pwdata;
            if (wr_ctrl)
            begin
                ctrl.irq_and_count_enable <= new_en;
                ctrl.rst_en               <= pwdata[HWD_CTRL_RST_EN_BIT];
            end
            if (next_lock == HWD_LOCKED || clear_end)
                clr_pending <= 1'b0;
            else if (wr_clear)
            begin
                clr_pending <= 1'b1;
                clr_byte    <= pwdata[HWD_CLEAR_W-1:0];
            end
        end
    end

    assign wdt_irq = irq_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // APB read path, one wait-free access phase
    function automatic logic [31:0] flag_at(input int pos, input logic val);
        flag_at      = 32'h0000_0000;
        flag_at[pos] = val;
    endfunction

    logic [31:0] rd_mux;
    logic [31:0] word_ctrl;
    logic [31:0] word_status;
    logic [31:0] word_key;

    assign word_ctrl   = flag_at(HWD_CTRL_IRQ_EN_BIT, ctrl.irq_and_count_enable) |
                         flag_at(HWD_CTRL_RST_EN_BIT, ctrl.rst_en);
    assign word_status = flag_at(0, irq_flag);
    assign word_key    = flag_at(HWD_KEY_LOCKED_BIT, lock == HWD_LOCKED) |
                         flag_at(HWD_KEY_CTRL_OPEN_BIT, lock == HWD_OPEN_ALL);

    // Count is read straight from the counter, not resynchronised
    assign rd_mux = sel_load   ? load        :
                    sel_count  ? count       :
                    sel_ctrl   ? word_ctrl   :
                    sel_status ? word_status :
                    sel_key    ? word_key    :
                                 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end
    end

    assign pready = psel & penable;

endmodule

//--- tb/hwd_wdt_properties.sv
// Purpose: Port-level checks of the hardware watchdog
// Assumes: One clock domain, rst_b active low
// Notes:   Bound to the top module
`timescale 1ns/10ps
module hwd_wdt_checker
    import hwd_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        low_speed_rc_clock,
    input wire logic        debug_break,
    input wire logic        wdt_irq,
    input wire logic        wdt_reset_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire logic acc = psel && penable;
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst_pulse; wdt_reset_req |=> !wdt_reset_req; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    property p_rst_flag; wdt_reset_req |-> $past(wdt_irq); endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("reset without flag");
    property p_irq_hold; wdt_irq && !(acc && pwrite) |=> wdt_irq || wdt_reset_req; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_osc; $rose(wdt_irq) |-> $past(low_speed_rc_clock, 2); endproperty
    a_irq_osc: assert property (p_irq_osc) else $error("irq without tick");
    property p_dbg_halt; debug_break [*8] |-> !$rose(wdt_irq); endproperty
    a_dbg_halt: assert property (p_dbg_halt) else $error("count in break");
    property p_status; acc && !pwrite && paddr == HWD_OFS_IRQ_STATUS
        |-> prdata == {31'h0000_0000, $past(wdt_irq)}; endproperty
    a_status: assert property (p_status) else $error("status mismatch");
    property p_clear_rd; acc && !pwrite && paddr == HWD_OFS_CLEAR |-> prdata == 32'h0000_0000;
    endproperty
    a_clear_rd: assert property (p_clear_rd) else $error("clear read not 0");
    property p_err; acc |-> pslverr == (paddr > HWD_OFS_KEY); endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
endmodule

bind hwd_hardware_watchdog hwd_wdt_checker u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_rc_clock(low_speed_rc_clock),
    .debug_break(debug_break), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));

//--- tb/hwd_apb_host.sv
// Purpose: Processor side of the register bus
// Assumes: Signals change only after rising edges
// Notes:   Released address and data are inverted
`timescale 1ns/10ps
module hwd_apb_host
(
    input  wire logic        mclk,
    output      logic        psel,
    output      logic        penable,
    output      logic        pwrite,
    output      logic [11:0] paddr,
    output      logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 64)
        begin
            n++;
            @(posedge mclk);
        end
        q = prdata;
        e = (n < 64) ? pslverr : 1'bx;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

//--- tb/hardware_watchdog_timer_tb_top.sv
// Purpose: Self-checking bench of the hardware watchdog
// Assumes: Oscillator phases of 6 mclk
// Notes:   Register table first, then lock, underflow, stop
`timescale 1ns/10ps
module hardware_watchdog_timer_tb_top
    import hwd_pkg::*;
;
    logic mclk = 1'b0, rst_b = 1'b0, low_speed_rc_clock = 1'b0, debug_break = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, wdt_irq, wdt_reset_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int errors = 0, compares = 0, resets = 0;
    typedef struct { logic [11:0] a; logic [31:0] d; logic e; } hwd_row_t;
    hwd_row_t rows [7] = '{'{HWD_OFS_LOAD, 32'h0000_FFFF, 1'b0},
        '{HWD_OFS_COUNT_VALUE, 32'h0000_FFFF, 1'b0}, '{HWD_OFS_CONTROL, 32'h0000_0003, 1'b0},
        '{HWD_OFS_CLEAR, 32'h0000_0000, 1'b0}, '{HWD_OFS_IRQ_STATUS, 32'h0000_0000, 1'b0},
        '{HWD_OFS_KEY, 32'h0000_0001, 1'b0}, '{12'h018, 32'h0000_0000, 1'b1}};
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (wdt_reset_req === 1'b1) resets <= resets + 1;
    hwd_hardware_watchdog dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_speed_rc_clock(low_speed_rc_clock),
        .debug_break(debug_break), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));
    hwd_apb_host u_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (exp !== got)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk($sformatf("reg %h", a), exp, q);
        chk("read error", 32'h0000_0000, {31'h0000_0000, e});
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b1, a, d, q, e);
        chk("write error", 32'h0000_0000, {31'h0000_0000, e});
    endtask
    task tick(input int n);
        repeat (n)
        begin
            repeat (6) @(posedge mclk);
            low_speed_rc_clock <= 1'b1;
            repeat (6) @(posedge mclk);
            low_speed_rc_clock <= 1'b0;
        end
        repeat (6) @(posedge mclk);
    endtask
    task unlock(input logic both);
        wr(HWD_OFS_KEY, HWD_KEY_FIRST);
        if (both)
            wr(HWD_OFS_KEY, HWD_KEY_SECOND);
    endtask
    // Whole run needs about 410 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        summarize();
    end
    initial
    begin
        logic [31:0] q;
        logic e;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[i])
        begin
            u_host.xfer(1'b0, rows[i].a, 32'h0000_0000, q, e);
            chk("row data", rows[i].d, q);
            chk("row error", {31'h0000_0000, rows[i].e}, {31'h0000_0000, e});
        end
        $display("test reset values done");
        wr(HWD_OFS_LOAD, 32'h0000_0005);
        rd(HWD_OFS_LOAD, 32'h0000_FFFF);
        unlock(1'b0);
        rd(HWD_OFS_KEY, 32'h0000_0000);
        wr(HWD_OFS_CONTROL, 32'h0000_0000);
        rd(HWD_OFS_CONTROL, 32'h0000_0003);
        unlock(1'b0);
        wr(HWD_OFS_KEY, 32'h0000_1234);
        rd(HWD_OFS_KEY, 32'h0000_0001);
        unlock(1'b1);
        rd(HWD_OFS_KEY, 32'h0000_0002);
        wr(HWD_OFS_LOAD, 32'h0000_0003);
        rd(HWD_OFS_KEY, 32'h0000_0001);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_0003);
        $display("test lock done");
        tick(3);
        chk("irq", 32'h0000_0000, {31'h0000_0000, wdt_irq});
        tick(1);
        chk("irq", 32'h0000_0001, {31'h0000_0000, wdt_irq});
        rd(HWD_OFS_IRQ_STATUS, 32'h0000_0001);
        tick(1);
        unlock(1'b0);
        wr(HWD_OFS_CLEAR, 32'h0000_005A);
        wr(HWD_OFS_CLEAR, 32'h0000_00A5);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_0003);
        rd(HWD_OFS_IRQ_STATUS, 32'h0000_0000);
        rd(HWD_OFS_KEY, 32'h0000_0001);
        tick(8);
        chk("resets", 32'h0000_0001, resets);
        rd(HWD_OFS_LOAD, 32'h0000_FFFF);
        $display("test underflow done");
        unlock(1'b1);
        wr(HWD_OFS_CONTROL, 32'h0000_0000);
        rd(HWD_OFS_CONTROL, 32'h0000_0000);
        tick(2);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_FFFF);
        wr(HWD_OFS_CONTROL, 32'h0000_0001);
        tick(1);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_FFFE);
        debug_break <= 1'b1;
        tick(2);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_FFFE);
        debug_break <= 1'b0;
        tick(1);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_FFFD);
        $display("test stop done");
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(HWD_OFS_KEY, 32'h0000_0001);
        rd(HWD_OFS_CONTROL, 32'h0000_0003);
        rd(HWD_OFS_COUNT_VALUE, 32'h0000_FFFF);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
